// *** fess_defines.svh ***
// Constants of the flash erase and status sequencer: offsets, fields,
// reset values, command codes and timing figures.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FESS_DEFINES_SVH
`define FESS_DEFINES_SVH

// ***************************************************************
// Timing
// ***************************************************************
`define FESS_CLK_KHZ      25000
`define FESS_OSC_MS       30
`define FESS_SETUP_MS     10
`define FESS_ERASE_MS     100
`define FESS_TMR_W        24

// ***************************************************************
// Programmer command codes
// ***************************************************************
`define FESS_CMD_READ     8'h00
`define FESS_CMD_ERASE    8'h20
`define FESS_CMD_STATUS   8'h71

// ***************************************************************
// Register offsets and reset values
// ***************************************************************
`define FESS_OFF_CTRL     8'h00
`define FESS_OFF_LIMIT    8'h04
`define FESS_OFF_STATUS   8'h08
`define FESS_OFF_COUNT    8'h0c
`define FESS_CTRL_RST     1'h0
`define FESS_LIMIT_RST    16'h0000
`define FESS_COUNT_RST    16'h0000
`define FESS_SBYTE_RST    8'h00

// ***************************************************************
// Field positions
// ***************************************************************
`define FESS_CTRL_FAIL    0
`define FESS_SB_ABN       7
`define FESS_SB_CMD       6
`define FESS_SB_PRG       5
`define FESS_SB_ERS       4
`define FESS_SB_CNT       1
`define FESS_SB_ADR       0
`define FESS_ST_END       8
`define FESS_ST_RES       9
`define FESS_ST_BUSY      10
`define FESS_ST_RDY       11

`endif

// *** fess_pkg.sv ***
// Types shared by the flash erase and status sequencer modules.
// Assumes fess_defines.svh is on the include path.
`include "fess_defines.svh"

package fess_pkg;

   typedef enum logic [6:0]
   {
      ST_BOOT    = 7'h01,
      ST_MEMRD   = 7'h02,
      ST_WAIT    = 7'h04,
      ST_ERS2    = 7'h08,
      ST_STS2    = 7'h10,
      ST_ERASING = 7'h20,
      ST_STATUS  = 7'h40
   } fess_state_e;

   typedef struct packed
   {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        write_gate;
      logic [17:0] addr;
      logic [7:0]  wdata;
   } fess_pbus_s;

   typedef struct packed
   {
      logic       oe;
      logic [7:0] data;
   } fess_pdout_s;

endpackage : fess_pkg

// *** fess_timer.sv ***
// Down-counter used for the start-up delay and for the erase time.
// Assumes the loader holds off reading done until the cycle after load.
`include "fess_defines.svh"

module fess_timer
(
   // Clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // Control
   input  wire logic                   load,
   input  wire logic [`FESS_TMR_W-1:0] load_val,
   output logic                        done
);

   logic [`FESS_TMR_W-1:0] count;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count <= '0;
      else if (load)
         count <= load_val;
      else if (count != '0)
         count <= count - `FESS_TMR_W'(1);
   end

   assign done = (count == '0);

endmodule : fess_timer

// *** fess_axil.sv ***
// AXI4-Lite slave front end: takes one write and one read at a time and
// hands each to the register file as a one-cycle request.
// Assumes the register file answers rd_data and both errors in the same cycle.
module fess_axil
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write channels
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // Read channels
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Register file side
   output logic             wr_req,
   output logic [7:0]       wr_addr,
   output logic [31:0]      wr_data,
   output logic [3:0]       wr_strb,
   input  wire logic        wr_err,
   output logic             rd_req,
   output logic [7:0]       rd_addr,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_err
);

   // The ready outputs are the free flags themselves, so they come from flops.
   assign wr_req = !awready && !wready && !bvalid;
   assign rd_req = !arready && !rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= 2'h0;
         wr_addr <= 8'h00;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            awready <= 1'b0;
            wr_addr <= awaddr;
         end
         if (wvalid && wready)
         begin
            wready  <= 1'b0;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (wr_req)
         begin
            bvalid  <= 1'b1;
            bresp   <= wr_err ? 2'h2 : 2'h0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rresp   <= 2'h0;
         rdata   <= 32'h0000_0000;
         rd_addr <= 8'h00;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rd_addr <= araddr;
      end
      else if (rd_req)
      begin
         rvalid <= 1'b1;
         rdata  <= rd_data;
         rresp  <= rd_err ? 2'h2 : 2'h0;
      end
      else if (rvalid && rready)
      begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

endmodule : fess_axil

// *** fess_top.sv ***
// Programmer-mode sequencer of the on-chip flash: whole-array erase,
// status read mode, status polling and start-up command lockout.
// Assumes programmer pins are synchronous to aclk and the array is outside.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`include "fess_defines.svh"

module fess_top
#(
   parameter int unsigned START_CYC = (`FESS_OSC_MS + `FESS_SETUP_MS) * `FESS_CLK_KHZ,
   parameter int unsigned ERASE_CYC = `FESS_ERASE_MS * `FESS_CLK_KHZ
)
(
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Programmer bus
   input  wire fess_pkg::fess_pbus_s pbus,
   output fess_pkg::fess_pdout_s     pdout,
   // Flash array
   input  wire logic [7:0]           array_rdata,
   output logic                      erase_all,
   // AXI4-Lite write channels
   input  wire logic [7:0]           awaddr,
   input  wire logic                 awvalid,
   output logic                      awready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output logic                      wready,
   output logic [1:0]                bresp,
   output logic                      bvalid,
   input  wire logic                 bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]           araddr,
   input  wire logic                 arvalid,
   output logic                      arready,
   output logic [31:0]               rdata,
   output logic [1:0]                rresp,
   output logic                      rvalid,
   input  wire logic                 rready
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   fess_pkg::fess_state_e  state;
   fess_pkg::fess_state_e  next_state;
   logic                   we_q;
   logic                   wr_evt;
   logic                   cmd_ok;
   logic                   boot_armed;
   logic                   tmr_load;
   logic [`FESS_TMR_W-1:0] tmr_val;
   logic                   tmr_done;
   logic [7:0]             status_byte;
   logic [7:0]             err_set;
   logic                   operation_end_flag;
   logic                   completion_result_flag;
   logic                   poll_hold;
   logic                   poll_set;
   logic                   poll_ok;
   logic                   erase_start;
   logic                   erase_good;
   logic                   fail_inject;
   logic [15:0]            erase_limit;
   logic [15:0]            erase_count;
   logic                   wr_req;
   logic [7:0]             wr_addr;
   logic [31:0]            wr_data;
   logic [3:0]             wr_strb;
   logic                   wr_err;
   logic                   rd_req;
   logic [7:0]             rd_addr;
   logic [31:0]            rd_data;
   logic                   rd_err;
   fess_pkg::fess_pdout_s  next_pdout;

   function automatic logic fess_hit(input logic [7:0] a, input logic [7:0] off);
      fess_hit = (a[7:2] == off[7:2]);
   endfunction : fess_hit

   // ***************************************************************
   // Command write detection
   // ***************************************************************
   // A write is taken on the rising write strobe while chip select is low.
   assign wr_evt = !pbus.ce_n && pbus.we_n && !we_q;
   assign cmd_ok = wr_evt && (state != fess_pkg::ST_BOOT) && (state != fess_pkg::ST_ERASING);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         we_q <= 1'b1;
      else
         we_q <= pbus.we_n;
   end

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   always_comb
   begin
      next_state  = state;
      err_set     = 8'h00;
      erase_start = 1'b0;
      erase_good  = 1'b0;
      poll_set    = 1'b0;
      poll_ok     = 1'b0;
      tmr_load    = 1'b0;
      tmr_val     = `FESS_TMR_W'(ERASE_CYC);
      case (state)
         fess_pkg::ST_BOOT:
         begin
            if (!boot_armed)
            begin
               tmr_load = 1'b1;
               tmr_val  = `FESS_TMR_W'(START_CYC);
            end
            else if (tmr_done)
               next_state = fess_pkg::ST_MEMRD;
         end
         fess_pkg::ST_ERS2:
         begin
            if (cmd_ok)
            begin
               next_state = fess_pkg::ST_WAIT;
               if (pbus.wdata != `FESS_CMD_ERASE)
                  err_set[`FESS_SB_CMD] = 1'b1;
               else if (!pbus.write_gate)
               begin
                  err_set[`FESS_SB_ERS] = 1'b1;
                  poll_set = 1'b1;
               end
               else if ((erase_limit != 16'h0000) && (erase_count >= erase_limit))
               begin
                  err_set[`FESS_SB_CNT] = 1'b1;
                  poll_set = 1'b1;
               end
               else
               begin
                  erase_start = 1'b1;
                  tmr_load    = 1'b1;
                  next_state  = fess_pkg::ST_ERASING;
               end
            end
         end
         fess_pkg::ST_STS2:
         begin
            if (cmd_ok)
            begin
               if (pbus.wdata == `FESS_CMD_STATUS)
                  next_state = fess_pkg::ST_STATUS;
               else
               begin
                  next_state = fess_pkg::ST_WAIT;
                  err_set[`FESS_SB_CMD] = 1'b1;
               end
            end
         end
         fess_pkg::ST_ERASING:
         begin
            if (tmr_done)
            begin
               next_state = fess_pkg::ST_WAIT;
               poll_set   = 1'b1;
               if (fail_inject)
                  err_set[`FESS_SB_ERS] = 1'b1;
               else
               begin
                  erase_good = 1'b1;
                  poll_ok    = 1'b1;
               end
            end
         end
         default:
         begin
            if (cmd_ok)
            begin
               if (pbus.wdata == `FESS_CMD_READ)
                  next_state = fess_pkg::ST_MEMRD;
               else if (pbus.wdata == `FESS_CMD_ERASE)
                  next_state = fess_pkg::ST_ERS2;
               else if (pbus.wdata == `FESS_CMD_STATUS)
                  next_state = (state == fess_pkg::ST_STATUS) ? fess_pkg::ST_STATUS : fess_pkg::ST_STS2;
               else
               begin
                  next_state = fess_pkg::ST_WAIT;
                  err_set[`FESS_SB_CMD] = 1'b1;
               end
            end
         end
      endcase
      if (err_set != 8'h00)
         err_set[`FESS_SB_ABN] = 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state      <= fess_pkg::ST_BOOT;
         boot_armed <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (tmr_load && (state == fess_pkg::ST_BOOT))
            boot_armed <= 1'b1;
      end
   end

   fess_timer u_timer
   (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   // The array sees one erase line only, so nothing smaller can be erased.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         erase_all <= 1'b0;
      else
         erase_all <= (next_state == fess_pkg::ST_ERASING);
   end

   // ***************************************************************
   // Status byte and polling flags
   // ***************************************************************
   // Clear first, then set, so an error raised by the clearing write stays.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_byte <= `FESS_SBYTE_RST;
      else if (cmd_ok && (pbus.wdata != `FESS_CMD_STATUS))
         status_byte <= err_set;
      else
         status_byte <= status_byte | err_set;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         poll_hold              <= 1'b0;
         operation_end_flag     <= 1'b0;
         completion_result_flag <= 1'b0;
      end
      else if (poll_set)
      begin
         poll_hold              <= 1'b1;
         operation_end_flag     <= poll_ok;
         completion_result_flag <= 1'b1;
      end
      else if (cmd_ok || erase_start)
         poll_hold <= 1'b0;
   end

   // ***************************************************************
   // Programmer data output
   // ***************************************************************
   always_comb
   begin
      next_pdout.oe   = !pbus.ce_n && !pbus.oe_n && pbus.we_n && (state != fess_pkg::ST_BOOT);
      next_pdout.data = 8'h00;
      if (state == fess_pkg::ST_ERASING)
         next_pdout.data = 8'h00;
      else if (state == fess_pkg::ST_STATUS)
         next_pdout.data = status_byte & 8'hf3;
      else if (poll_hold)
         next_pdout.data = {operation_end_flag, completion_result_flag, 6'h00};
      else if (state == fess_pkg::ST_MEMRD)
         next_pdout.data = array_rdata;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pdout <= '0;
      else
         pdout <= next_pdout;
   end

   // ***************************************************************
   // Register file
   // ***************************************************************
   assign wr_err = !(fess_hit(wr_addr, `FESS_OFF_CTRL) || fess_hit(wr_addr, `FESS_OFF_LIMIT));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fail_inject <= `FESS_CTRL_RST;
         erase_limit <= `FESS_LIMIT_RST;
      end
      else if (wr_req)
      begin
         if (fess_hit(wr_addr, `FESS_OFF_CTRL))
         begin
            if (wr_strb[0])
               fail_inject <= wr_data[`FESS_CTRL_FAIL];
         end
         else if (fess_hit(wr_addr, `FESS_OFF_LIMIT))
         begin
            for (int b = 0; b < 2; b++)
               if (wr_strb[b])
                  erase_limit[b*8 +: 8] <= wr_data[b*8 +: 8];
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         erase_count <= `FESS_COUNT_RST;
      else if (erase_good && (erase_count != 16'hffff))
         erase_count <= erase_count + 16'h0001;
   end

   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      if (fess_hit(rd_addr, `FESS_OFF_CTRL))
         rd_data[`FESS_CTRL_FAIL] = fail_inject;
      else if (fess_hit(rd_addr, `FESS_OFF_LIMIT))
         rd_data[15:0] = erase_limit;
      else if (fess_hit(rd_addr, `FESS_OFF_STATUS))
      begin
         rd_data[7:0]           = status_byte;
         rd_data[`FESS_ST_END]  = operation_end_flag;
         rd_data[`FESS_ST_RES]  = completion_result_flag;
         rd_data[`FESS_ST_BUSY] = (state == fess_pkg::ST_ERASING);
         rd_data[`FESS_ST_RDY]  = (state != fess_pkg::ST_BOOT);
      end
      else if (fess_hit(rd_addr, `FESS_OFF_COUNT))
         rd_data[15:0] = erase_count;
      else
         rd_err = 1'b1;
   end

   fess_axil u_axil
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_req  (wr_req),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_err  (wr_err),
      .rd_req  (rd_req),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_err  (rd_err)
   );

endmodule : fess_top

// *** fess_top_asserts.sv ***
// Port checker for the flash sequencer top.
// Assumes a bind from the bench with the same counts.
module fess_top_asserts
#(
   parameter int unsigned START_CYC = 20,
   parameter int unsigned ERASE_CYC = 50
)
(
   // Clock and reset
   input wire logic                  aclk,
   input wire logic                  aresetn,
   // Programmer side
   input wire fess_pkg::fess_pbus_s  pbus,
   input wire fess_pkg::fess_pdout_s pdout,
   input wire logic                  erase_all,
   // Register bus
   input wire logic                  awvalid,
   input wire logic                  awready,
   input wire logic                  wvalid,
   input wire logic                  wready,
   input wire logic                  bvalid,
   input wire logic                  arvalid,
   input wire logic                  arready,
   input wire logic                  rvalid
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] boot_cnt;
   logic [31:0] ers_cnt;
   logic        we_q;
   logic [8:0]  last_cmd;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         boot_cnt <= '0;
      else if (boot_cnt <= START_CYC)
         boot_cnt <= boot_cnt + 1;
   end
   always_ff @(posedge aclk)
   begin
      ers_cnt <= erase_all ? ers_cnt + 1 : '0;
   end
   // Last command taken on a rising strobe, with its gate level.
   always_ff @(posedge aclk)
   begin
      we_q <= pbus.we_n;
      if (!pbus.ce_n && pbus.we_n && !we_q)
         last_cmd <= {pbus.write_gate, pbus.wdata};
   end
   AST_RESET_IDLE: assert property ($rose(aresetn) |-> pdout == '0 && !erase_all && !bvalid && !rvalid)
      else $error("outputs not idle after reset");
   AST_OE_LAG: assert property (pdout.oe == $past(!pbus.ce_n && !pbus.oe_n && pbus.we_n && aresetn))
      else $error("data drive does not follow select");
   AST_BUSY_ZERO: assert property (erase_all && $past(erase_all) && pdout.oe |-> pdout.data == 8'h00)
      else $error("data lines not zero while erasing");
   AST_ERASE_LEN: assert property ($fell(erase_all) |-> ers_cnt inside {[ERASE_CYC - 1 : ERASE_CYC + 1]})
      else $error("erase length wrong");
   AST_BOOT_LOCK: assert property (boot_cnt <= START_CYC |-> !erase_all)
      else $error("erase started during lockout");
   AST_ERASE_CMD: assert property ($rose(erase_all) |-> last_cmd == 9'h120)
      else $error("erase without gated erase command");
   AST_RD_ANSWER: assert property (arvalid && arready |-> ##2 rvalid)
      else $error("read answer late");
   AST_WR_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write answer late");
endmodule : fess_top_asserts

// *** fess_prog_model.sv ***
// Behavioural programmer on the parallel bus.
// Assumes the bench calls one task at a time.
module fess_prog_model
(
   // Clock
   input  wire logic                  aclk,
   // Parallel bus
   output fess_pkg::fess_pbus_s       pbus,
   input  wire fess_pkg::fess_pdout_s pdout
);
   timeunit 1ns;
   timeprecision 1ns;
   time t_last = 0;
   initial pbus = {3'b111, 1'b0, 18'h0, 8'hff};
   // Spacing after a command stands in for the polling start time, scaled to the bench's short erase.
   task automatic hold_off();
      while ($time < t_last + 20000)
         @(posedge aclk);
   endtask : hold_off
   task automatic wr(input logic [7:0] d, input logic g);
      hold_off();
      @(posedge aclk);
      pbus <= {3'b010, g, 18'h0, d};
      @(posedge aclk);
      pbus.we_n <= 1'b1;
      @(posedge aclk);
      pbus <= {3'b111, 1'b0, 18'h0, ~d};
      t_last = $time;
      repeat (2) @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [17:0] a, output logic [8:0] q);
      hold_off();
      @(posedge aclk);
      pbus <= {3'b001, 1'b0, a, pbus.wdata};
      repeat (3) @(posedge aclk);
      #1 q = pdout;
      @(posedge aclk);
      pbus <= {3'b111, 1'b0, 18'h0, pbus.wdata};
   endtask : rd
endmodule : fess_prog_model

// *** tb_flash_erase_status_sequencer.sv ***
// Bench for the flash sequencer: programmer model and register master.
// Assumes short lockout and erase counts in place of the real ones.
module tb_flash_erase_status_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned SC = 1200;
   localparam int unsigned EC = 1000;
   logic                  aclk = 1'b0;
   logic                  aresetn = 1'b0;
   fess_pkg::fess_pbus_s  pbus;
   fess_pkg::fess_pdout_s pdout;
   logic                  erase_all, awready, wready, bvalid, arready, rvalid;
   logic [7:0]            awaddr = 8'h00, araddr = 8'h00;
   logic                  awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
   logic [31:0]           wdata = 32'h0, rdata, r, d;
   logic [1:0]            bresp, rresp, rr;
   logic [8:0]            q;
   int                    errors = 0, n_tests = 0, cyc = 0, seed = 25, k, j;
   fess_top #(.START_CYC(SC), .ERASE_CYC(EC)) dut (.aclk, .aresetn, .pbus, .pdout,
      .array_rdata(pbus.addr[7:0] ^ 8'ha5), .erase_all, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
   fess_prog_model prog (.aclk, .pbus, .pdout);
   always #20 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
      $display("test %s done", nm);
   endtask : chk
   // Status code expected after a failed erase: count limit for kk 1, erase error otherwise.
   function automatic logic [8:0] exp_code(input int kk);
      exp_code = {2'b11, 2'b00, kk != 1, 2'b00, kk == 1, 1'b0};
   endfunction : exp_code
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (!bvalid);
      rr = bresp;
      bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (!rvalid);
      r = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask : axr
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (k = 0; k < 4; k++)
      begin
         axr(8'(4 * k));
         chk("reg reset", 0, r);
      end
      d = $random(seed);
      axw(8'h04, d);
      chk("wr resp", 0, rr);
      axr(8'h04);
      chk("limit", {16'h0, d[15:0]}, r);
      axr(8'h10);
      chk("unmapped", 36'h2_0000_0000, {rr, r});
      axw(8'h10, d);
      chk("wr unmapped", 2, rr);
      prog.wr(8'h20, 1'b1);
      prog.wr(8'h20, 1'b1);
      chk("boot erase", 0, erase_all);
      repeat (SC) @(posedge aclk);
      for (k = 0; k < 3; k++)
      begin
         d = $random(seed);
         prog.rd(d[17:0], q);
         chk("mem read", {1'b1, d[7:0] ^ 8'ha5}, q);
      end
      prog.wr(8'h20, 1'b1);
      prog.wr(8'h20, 1'b1);
      chk("erase on", 1, erase_all);
      prog.rd(18'h0, q);
      chk("poll busy", 9'h100, q);
      while (erase_all)
         @(posedge aclk);
      prog.rd(18'h0, q);
      chk("poll done", 9'h1c0, q);
      prog.rd(18'h3, q);
      chk("poll held", 9'h1c0, q);
      axr(8'h0c);
      chk("count", 1, r);
      axr(8'h08);
      chk("flags reg", 4'hb, r[11:8]);
      prog.wr(8'h71, 1'b0);
      prog.wr(8'h71, 1'b0);
      prog.rd(18'h0, q);
      chk("status ok", 9'h100, q);
      // A bad second erase cycle and random unknown codes must all flag.
      for (k = 0; k < 4; k++)
      begin
         d = $random(seed);
         if (d[7:0] == 8'h00 || d[7:0] == 8'h20 || d[7:0] == 8'h71)
            d[7:0] = 8'h40;
         if (k == 0)
            prog.wr(8'h20, 1'b1);
         prog.wr(d[7:0], 1'b0);
         for (j = 0; j < 3; j++)
            prog.wr(8'h71, 1'b0);
         prog.rd(18'h0, q);
         chk("cmd error", 9'h1c0, q);
      end
      prog.wr(8'h00, 1'b0);
      prog.wr(8'h71, 1'b0);
      prog.wr(8'h71, 1'b0);
      prog.rd(18'h0, q);
      chk("code cleared", 9'h100, q);
      for (k = 0; k < 3; k++)
      begin
         axw(8'h04, 32'(k == 1));
         axw(8'h00, 32'(k == 2));
         prog.wr(8'h20, 1'b1);
         prog.wr(8'h20, k != 0);
         chk("erase run", k == 2, erase_all);
         while (erase_all)
            @(posedge aclk);
         prog.rd(18'h0, q);
         chk("poll fail", 9'h140, q);
         prog.wr(8'h71, 1'b0);
         prog.wr(8'h71, 1'b0);
         prog.rd(18'h0, q);
         chk("fail code", exp_code(k), q);
      end
      tally_and_finish();
   end
endmodule : tb_flash_erase_status_sequencer

bind fess_top fess_top_asserts #(.START_CYC(START_CYC), .ERASE_CYC(ERASE_CYC)) chk_u (.aclk, .aresetn, .pbus,
   .pdout, .erase_all, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid);
